// *** rtl/tmrirq_top.sv ***
/*
 interrupt enable and status registers of a 16-bit timer, four channels.
 assumes the counter, general registers, roles and capture pulses
 come from timer logic on the same clock; no synchronisers needed.
*/
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module tmrirq_top
(
   // clock, reset, enable
   input wire logic REF_CLK_I,
   input wire logic SRST_I,
   input wire logic CE_I,
   // register port
   input wire logic [tmrirq_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic [tmrirq_pkg::DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [tmrirq_pkg::DATA_W-1:0] RDATA_O,
   // timer core
   input wire logic [tmrirq_pkg::CNT_W-1:0] TIMER_COUNT_VALUE_I,
   input wire logic [tmrirq_pkg::CNT_W-1:0] GENERAL_REG_A_I,
   input wire logic [tmrirq_pkg::CNT_W-1:0] GENERAL_REG_B_I,
   input wire logic [tmrirq_pkg::CNT_W-1:0] GENERAL_REG_C_I,
   input wire logic [tmrirq_pkg::CNT_W-1:0] GENERAL_REG_D_I,
   input wire logic [tmrirq_pkg::NUM_CH-1:0] CAPTURE_ROLE_I,
   input wire logic [tmrirq_pkg::NUM_CH-1:0] CAPTURE_I,
   // interrupt requests
   output logic OVERFLOW_IRQ_REQUEST_O,
   output logic MATCH_IRQ_REQUEST_A_O,
   output logic MATCH_IRQ_REQUEST_B_O,
   output logic MATCH_IRQ_REQUEST_C_O,
   output logic MATCH_IRQ_REQUEST_D_O,
   output logic IRQ_O
);
   localparam int unsigned NS = tmrirq_pkg::NUM_SRC;
   localparam int unsigned NC = tmrirq_pkg::NUM_CH;
   localparam int unsigned DW = tmrirq_pkg::DATA_W;
   localparam int unsigned CW = tmrirq_pkg::CNT_W;

   logic [CW-1:0] cnt_q;
   logic [NS-1:0] en_q;
   logic [NS-1:0] en_d;
   logic [NS-1:0] req_q;
   logic [NS-1:0] req_d;
   logic irq_q;
   logic [DW-1:0] rdata_q;
   logic [DW-1:0] rdata_d;
   logic [NS-1:0] flag;
   logic [NS-1:0] flag_d;
   logic [NS-1:0] src_evt;
   logic [NS-1:0] wbits;
   logic [NC-1:0] cmp_hit;
   logic [NC-1:0] cap_hit;
   logic [CW-1:0] gr [NC];
   logic wr_en;
   logic wr_st;
   logic rd_en;
   logic rd_st;
   logic cnt_moved;
   logic ovf_evt;
   logic [DW-1:0] en_view;
   logic [DW-1:0] st_view;

   // address decode
   assign wr_en = WR_I && (ADDR_I == tmrirq_pkg::ADDR_IRQ_ENABLE);
   assign wr_st = WR_I && (ADDR_I == tmrirq_pkg::ADDR_IRQ_STATUS);
   assign rd_en = RD_I && (ADDR_I == tmrirq_pkg::ADDR_IRQ_ENABLE);
   assign rd_st = RD_I && (ADDR_I == tmrirq_pkg::ADDR_IRQ_STATUS);

   // live bits of a write byte, reserved lanes dropped
   assign wbits = {WDATA_I[tmrirq_pkg::BIT_OVF],
                   WDATA_I[tmrirq_pkg::CH_HI:0]};

   // overflow: previous value at max, now zero
   assign ovf_evt = (cnt_q == tmrirq_pkg::CNT_MAX)
                 && (TIMER_COUNT_VALUE_I == tmrirq_pkg::CNT_ZERO);
   // equality counts once per counter step, not every clock it lasts
   assign cnt_moved = (TIMER_COUNT_VALUE_I != cnt_q);

   assign gr[0] = GENERAL_REG_A_I;
   assign gr[1] = GENERAL_REG_B_I;
   assign gr[2] = GENERAL_REG_C_I;
   assign gr[3] = GENERAL_REG_D_I;

   genvar ch;
   generate
      for (ch = 0; ch < NC; ch++)
      begin : g_ch
         assign cmp_hit[ch] = !CAPTURE_ROLE_I[ch] && cnt_moved
                           && (TIMER_COUNT_VALUE_I == gr[ch]);
         assign cap_hit[ch] = CAPTURE_ROLE_I[ch]
                           && CAPTURE_I[ch];
         assign src_evt[ch] = cmp_hit[ch] | cap_hit[ch];
      end
   endgenerate
   assign src_evt[tmrirq_pkg::SRC_OVF] = ovf_evt;

   genvar s;
   generate
      for (s = 0; s < NS; s++)
      begin : g_flag
         tmrirq_flag u_flag
         (
            .clk_i(REF_CLK_I),
            .srst_i(SRST_I),
            .ce_i(CE_I),
            .set_i(src_evt[s]),
            .rd_i(rd_st),
            .wr_i(wr_st),
            .wbit_i(wbits[s]),
            .flag_o(flag[s]),
            .flag_d_o(flag_d[s])
         );
      end
   endgenerate

   assign en_d = wr_en ? wbits : en_q;
   // next-state terms so requests follow the flag in the same cycle
   assign req_d = flag_d & en_d;

   // reserved lanes always read one
   assign en_view = {en_q[tmrirq_pkg::SRC_OVF], tmrirq_pkg::RSVD_READ,
                     en_q[tmrirq_pkg::CH_HI:0]};
   assign st_view = {flag[tmrirq_pkg::SRC_OVF], tmrirq_pkg::RSVD_READ,
                     flag[tmrirq_pkg::CH_HI:0]};
   // unmapped or idle reads return zero
   assign rdata_d = rd_en ? en_view
                  : (rd_st ? st_view : tmrirq_pkg::RDATA_IDLE);

   always_ff @(posedge REF_CLK_I)
   begin
      if (SRST_I)
      begin
         cnt_q <= tmrirq_pkg::CNT_ZERO;
         en_q <= tmrirq_pkg::SRC_RESET;
         req_q <= tmrirq_pkg::SRC_RESET;
         irq_q <= 1'b0;
         rdata_q <= tmrirq_pkg::RDATA_IDLE;
      end
      else if (CE_I)
      begin
         cnt_q <= TIMER_COUNT_VALUE_I;
         en_q <= en_d;
         req_q <= req_d;
         irq_q <= |req_d;
         rdata_q <= rdata_d;
      end
   end

   assign RDATA_O = rdata_q;
   assign OVERFLOW_IRQ_REQUEST_O = req_q[tmrirq_pkg::SRC_OVF];
   assign MATCH_IRQ_REQUEST_A_O = req_q[0];
   assign MATCH_IRQ_REQUEST_B_O = req_q[1];
   assign MATCH_IRQ_REQUEST_C_O = req_q[2];
   assign MATCH_IRQ_REQUEST_D_O = req_q[3];
   assign IRQ_O = irq_q;

   property p_ovf_req;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      OVERFLOW_IRQ_REQUEST_O == (flag[4] && en_q[4]);
   endproperty
   a_ovf_req: assert property (p_ovf_req)
      else $error("overflow request not flag and enable");

   property p_req_d;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      MATCH_IRQ_REQUEST_D_O == (flag[3] && en_q[3]);
   endproperty
   a_req_d: assert property (p_req_d)
      else $error("request d not flag and enable");

   property p_req_c;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      MATCH_IRQ_REQUEST_C_O == (flag[2] && en_q[2]);
   endproperty
   a_req_c: assert property (p_req_c)
      else $error("request c not flag and enable");

   property p_req_b;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      MATCH_IRQ_REQUEST_B_O == (flag[1] && en_q[1]);
   endproperty
   a_req_b: assert property (p_req_b)
      else $error("request b not flag and enable");

   property p_req_a;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      MATCH_IRQ_REQUEST_A_O == (flag[0] && en_q[0]);
   endproperty
   a_req_a: assert property (p_req_a)
      else $error("request a not flag and enable");

   property p_rsvd_ones;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      (CE_I && RD_I && (ADDR_I == tmrirq_pkg::ADDR_IRQ_ENABLE
         || ADDR_I == tmrirq_pkg::ADDR_IRQ_STATUS))
      |=> (RDATA_O[tmrirq_pkg::RSVD_HI:tmrirq_pkg::RSVD_LO]
         == tmrirq_pkg::RSVD_READ);
   endproperty
   a_rsvd_ones: assert property (p_rsvd_ones)
      else $error("reserved bits did not read as one");

   property p_ovf_set;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      (CE_I && $past(CE_I) && !$past(SRST_I)
         && $past(TIMER_COUNT_VALUE_I) == tmrirq_pkg::CNT_MAX
         && TIMER_COUNT_VALUE_I == tmrirq_pkg::CNT_ZERO) |=> flag[4];
   endproperty
   a_ovf_set: assert property (p_ovf_set)
      else $error("wrap did not set the overflow flag");

   property p_cap_d;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      (CE_I && CAPTURE_ROLE_I[3] && CAPTURE_I[3]) |=> flag[3];
   endproperty
   a_cap_d: assert property (p_cap_d)
      else $error("capture d did not set flag d");

   property p_cmp_c;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      (CE_I && !CAPTURE_ROLE_I[2] && TIMER_COUNT_VALUE_I == GENERAL_REG_C_I
         && TIMER_COUNT_VALUE_I != cnt_q) |=> flag[2];
   endproperty
   a_cmp_c: assert property (p_cmp_c)
      else $error("compare c did not set flag c");

   property p_cmp_b;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      (CE_I && !CAPTURE_ROLE_I[1] && TIMER_COUNT_VALUE_I == GENERAL_REG_B_I
         && TIMER_COUNT_VALUE_I != cnt_q) |=> flag[1];
   endproperty
   a_cmp_b: assert property (p_cmp_b)
      else $error("compare b did not set flag b");

   property p_cap_a;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      (CE_I && CAPTURE_ROLE_I[0] && CAPTURE_I[0]) |=> flag[0];
   endproperty
   a_cap_a: assert property (p_cap_a)
      else $error("capture a did not set flag a");

   property p_cmp_d;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      (CE_I && !CAPTURE_ROLE_I[3] && TIMER_COUNT_VALUE_I == GENERAL_REG_D_I
         && TIMER_COUNT_VALUE_I != cnt_q) |=> flag[3];
   endproperty
   a_cmp_d: assert property (p_cmp_d)
      else $error("compare d did not set flag d");

   property p_cap_c;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      (CE_I && CAPTURE_ROLE_I[2] && CAPTURE_I[2]) |=> flag[2];
   endproperty
   a_cap_c: assert property (p_cap_c)
      else $error("capture c did not set flag c");

   property p_cap_b;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      (CE_I && CAPTURE_ROLE_I[1] && CAPTURE_I[1]) |=> flag[1];
   endproperty
   a_cap_b: assert property (p_cap_b)
      else $error("capture b did not set flag b");

   property p_cmp_a;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      (CE_I && !CAPTURE_ROLE_I[0] && TIMER_COUNT_VALUE_I == GENERAL_REG_A_I
         && TIMER_COUNT_VALUE_I != cnt_q) |=> flag[0];
   endproperty
   a_cmp_a: assert property (p_cmp_a)
      else $error("compare a did not set flag a");

   // a clear overflow flag may only rise on a real wrap
   property p_ovf_only;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      (!flag[tmrirq_pkg::SRC_OVF] && !(cnt_q == tmrirq_pkg::CNT_MAX
         && TIMER_COUNT_VALUE_I == tmrirq_pkg::CNT_ZERO))
      |=> !flag[tmrirq_pkg::SRC_OVF];
   endproperty
   a_ovf_only: assert property (p_ovf_only)
      else $error("overflow flag set without a wrap");

   property p_mask_all;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      (CE_I && WR_I && ADDR_I == tmrirq_pkg::ADDR_IRQ_ENABLE
         && !WDATA_I[tmrirq_pkg::BIT_OVF]
         && WDATA_I[tmrirq_pkg::CH_HI:0] == '0) |=> !IRQ_O;
   endproperty
   a_mask_all: assert property (p_mask_all)
      else $error("irq stayed up with every enable written zero");

   property p_reset_zero;
      @(posedge REF_CLK_I)
      SRST_I |=> (en_q == 5'h00 && flag == 5'h00 && !IRQ_O);
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("state not zero after reset");

   property p_irq_any;
      @(posedge REF_CLK_I) disable iff (SRST_I)
      IRQ_O == (|(flag & en_q));
   endproperty
   a_irq_any: assert property (p_irq_any)
      else $error("irq output disagrees with requests");

   c_ovf_irq: cover property (@(posedge REF_CLK_I) disable iff (SRST_I)
      OVERFLOW_IRQ_REQUEST_O ##1 !OVERFLOW_IRQ_REQUEST_O);
   c_cap_irq: cover property (@(posedge REF_CLK_I) disable iff (SRST_I)
      cap_hit[3] ##1 MATCH_IRQ_REQUEST_D_O);
   c_cmp_irq: cover property (@(posedge REF_CLK_I) disable iff (SRST_I)
      cmp_hit[0] ##1 MATCH_IRQ_REQUEST_A_O);
endmodule : tmrirq_top

// *** rtl/tmrirq_pkg.sv ***
/*
 constants of the timer interrupt enable and status block.
 assumes one system clock and a same-clock timer core beside it.
*/
// Overview of operation
// - enable bit 7 passes the overflow request; zero blocks it.
// - enable bit 3 passes the channel D match or capture request.
// - enable bit 2 passes the channel C match or capture request.
// - enable bit 1 passes the channel B match or capture request.
// - enable bit 0 passes the channel A match or capture request.
// - bits 6 to 4 of both registers read as one, ignore writes.
// - overflow flag, status bit 7, sets when the counter wraps to zero.
// - flag D sets on compare equality or on capture into register D.
// - flag C sets on compare equality or on capture into register C.
// - flag B sets on compare equality or on capture into register B.
// - flag A sets on compare equality or on capture into register A.
// - a flag clears only by reading it as one, then writing zero.
// - after reset all enables and all flags are zero.
package tmrirq_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned ADDR_W = 2;
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned NUM_SRC = 5;
   // index of the overflow source in the five-bit vectors
   localparam int unsigned SRC_OVF = 4;
   // register offsets
   localparam logic [1:0] ADDR_IRQ_ENABLE = 2'h0;
   localparam logic [1:0] ADDR_IRQ_STATUS = 2'h1;
   // field positions in both registers
   localparam int unsigned BIT_OVF = 7;
   localparam int unsigned RSVD_HI = 6;
   localparam int unsigned RSVD_LO = 4;
   localparam int unsigned CH_HI = 3;
   localparam logic [2:0] RSVD_READ = 3'h7;
   // reset and idle values
   localparam logic [4:0] SRC_RESET = 5'h00;
   localparam logic [7:0] RDATA_IDLE = 8'h00;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
endpackage : tmrirq_pkg

// *** rtl/tmrirq_flag.sv ***
/*
 one status flag with its read-then-write-zero clearing.
 assumes strobes are one cycle and already decoded to the status register.
*/
`timescale 1ns/100ps
module tmrirq_flag
(
   // clock and control
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // events and bus strobes
   input wire logic set_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic wbit_i,
   // state
   output logic flag_o,
   output logic flag_d_o
);
   logic flag_q;
   logic flag_d;
   logic armed_q;
   logic armed_d;
   logic clr;

   // only a read that saw a one qualifies the next write
   assign clr = wr_i && !wbit_i && armed_q;
   assign flag_d = set_i | (flag_q & ~clr);
   // any status write consumes the arming, cleared or not
   assign armed_d = wr_i ? 1'b0 : (armed_q | (rd_i & flag_q));
   assign flag_o = flag_q;
   assign flag_d_o = flag_d;

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         flag_q <= 1'b0;
         armed_q <= 1'b0;
      end
      else if (ce_i)
      begin
         flag_q <= flag_d;
         armed_q <= armed_d;
      end
   end

   property p_clr_needs_read;
      @(posedge clk_i) disable iff (srst_i)
      (flag_q && !armed_q) |=> flag_q;
   endproperty
   a_clr_needs_read: assert property (p_clr_needs_read)
      else $error("flag cleared without a prior read of one");

   property p_read_then_zero;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && rd_i && flag_q && !wr_i) ##1 (ce_i && wr_i && !wbit_i
         && !set_i) |=> !flag_q;
   endproperty
   a_read_then_zero: assert property (p_read_then_zero)
      else $error("read then zero write did not clear the flag");

   property p_set_wins;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && set_i) |=> flag_q;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("set event lost");

   property p_write_one_keeps;
      @(posedge clk_i) disable iff (srst_i)
      (wr_i && wbit_i && flag_q) |=> flag_q;
   endproperty
   a_write_one_keeps: assert property (p_write_one_keeps)
      else $error("writing one changed the flag");

   c_clear_seen: cover property (@(posedge clk_i) disable iff (srst_i)
      flag_q ##1 !flag_q);
endmodule : tmrirq_flag

// *** sim/tmrirq_tb.sv ***
/*
 self-checking bench for the timer interrupt enable and status block.
 assumes the bench plays both bus master and timer core on one clock.
*/
`timescale 1ns/100ps
module testbench;
   logic clk, srst, ce, wr, rd;
   logic [1:0] addr;
   logic [7:0] wdata, rv;
   logic [15:0] cnt;
   logic [15:0] gr [4];
   logic [3:0] role, cap;
   wire [7:0] rdata;
   wire [3:0] req;
   wire ovf_req, irq;
   int err_count, checked;

   tmrirq_top tmrirq_top_inst
   (
      .REF_CLK_I(clk), .SRST_I(srst), .CE_I(ce),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .TIMER_COUNT_VALUE_I(cnt), .GENERAL_REG_A_I(gr[0]),
      .GENERAL_REG_B_I(gr[1]), .GENERAL_REG_C_I(gr[2]),
      .GENERAL_REG_D_I(gr[3]), .CAPTURE_ROLE_I(role), .CAPTURE_I(cap),
      .OVERFLOW_IRQ_REQUEST_O(ovf_req), .MATCH_IRQ_REQUEST_A_O(req[0]),
      .MATCH_IRQ_REQUEST_B_O(req[1]), .MATCH_IRQ_REQUEST_C_O(req[2]),
      .MATCH_IRQ_REQUEST_D_O(req[3]), .IRQ_O(irq)
   );

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task report_and_stop;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   task check(input string name, input logic [7:0] seen,
      input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // strobe for one cycle, return just after the sampling edge
   task wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg

   task rd_reg(input logic [1:0] a);
      @(posedge clk);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask : rd_reg

   task clear_chk(input int idx);
      rd_reg(2'h1);
      wr_reg(2'h1, ~(8'h01 << idx));
      check("request after clear", {3'h0, ovf_req, req}, 8'h00);
      rd_reg(2'h1);
      check("status after clear", rv, 8'h70);
   endtask : clear_chk

   task t_reset;
      rd_reg(2'h0);
      check("enable reset", rv, 8'h70);
      @(posedge clk);
      #1 check("rdata after read", rdata, 8'h00);
      rd_reg(2'h1);
      check("status reset", rv, 8'h70);
      check("requests reset", {2'h0, irq, ovf_req, req}, 8'h00);
      rd_reg(2'h2);
      check("unmapped read", rv, 8'h00);
      wr_reg(2'h0, 8'hFF);
      rd_reg(2'h0);
      check("enable all ones", rv, 8'hFF);
      wr_reg(2'h0, 8'h00);
      wr_reg(2'h3, 8'hFF);
      rd_reg(2'h0);
      check("reserved write", rv, 8'h70);
      @(posedge clk) ce <= 1'b0;
      wr_reg(2'h0, 8'h8F);
      @(posedge clk) ce <= 1'b1;
      rd_reg(2'h0);
      check("write while frozen", rv, 8'h70);
   endtask : t_reset

   task t_channels;
      for (int ch = 0; ch < 4; ch++)
      begin
         wr_reg(2'h0, 8'h01 << ch);
         @(posedge clk) cnt <= gr[ch];
         repeat (3) @(posedge clk);
         #1 check("compare request", {3'h0, irq, req},
            8'h10 | (8'h01 << ch));
         rd_reg(2'h1);
         check("compare flag", rv, 8'h70 | (8'h01 << ch));
         clear_chk(ch);
         @(posedge clk);
         role[ch] <= 1'b1; cap[ch] <= 1'b1;
         @(posedge clk) cap[ch] <= 1'b0;
         #1 rd_reg(2'h1);
         check("capture flag", rv, 8'h70 | (8'h01 << ch));
         wr_reg(2'h0, 8'h8F & ~(8'h01 << ch));
         check("masked request", {3'h0, irq, req}, 8'h00);
         role[ch] <= 1'b0;
         clear_chk(ch);
      end
   endtask : t_channels

   // flag must survive writes of one, unarmed zeros and a coinciding wrap
   task t_overflow;
      wr_reg(2'h0, 8'h80);
      @(posedge clk) cnt <= 16'hFFFF;
      @(posedge clk) cnt <= 16'h0000;
      repeat (2) @(posedge clk);
      #1 check("overflow request", {6'h0, irq, ovf_req}, 8'h03);
      rd_reg(2'h1);
      check("overflow flag", rv, 8'hF0);
      wr_reg(2'h1, 8'hFF);
      wr_reg(2'h1, 8'h00);
      rd_reg(2'h1);
      check("unarmed clear", rv, 8'hF0);
      wr_reg(2'h0, 8'h00);
      check("overflow masked", {6'h0, irq, ovf_req}, 8'h00);
      @(posedge clk) cnt <= 16'hFFFF;
      rd_reg(2'h1);
      @(posedge clk);
      wr <= 1'b1; addr <= 2'h1; wdata <= 8'h00; cnt <= 16'h0000;
      @(posedge clk) wr <= 1'b0;
      #1 rd_reg(2'h1);
      check("set beats clear", rv, 8'hF0);
      clear_chk(7);
   endtask : t_overflow

   // reset in mid-run must drop a live flag, enable and request
   task t_midreset;
      wr_reg(2'h0, 8'h81);
      @(posedge clk);
      role[0] <= 1'b1; cap[0] <= 1'b1;
      @(posedge clk) cap[0] <= 1'b0;
      #1 check("request before reset", {6'h0, irq, req[0]}, 8'h03);
      @(posedge clk) srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      role[0] <= 1'b0;
      #1 check("requests after reset", {2'h0, irq, ovf_req, req}, 8'h00);
      rd_reg(2'h0);
      check("enable after reset", rv, 8'h70);
      rd_reg(2'h1);
      check("status after reset", rv, 8'h70);
   endtask : t_midreset

   initial
   begin
      srst = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0;
      addr = 2'h0; wdata = 8'h00; cnt = 16'h0000;
      role = 4'h0; cap = 4'h0; err_count = 0; checked = 0;
      for (int i = 0; i < 4; i++)
         gr[i] = 16'h1000 + 16'h0111 * i;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_channels();
      t_overflow();
      t_midreset();
      report_and_stop();
   end

   // whole run is under two hundred cycles; this leaves wide margin
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      report_and_stop();
   end
endmodule : testbench
